// ---- common/pci_window_params.svh ----
// Constants for the PCI window bring-up: configuration header, bridge offsets and bus codes
// Summary of operation
// R1: Two base registers: bridge, counter registers.
// R2: Each region decodes 4 KB, memory only.
// R3: Bases at 0x10, 0x14; host may relocate.
// R4: Host writes unlock word before second relocation.
// R5: Window value opens forwarding to counter region.
// R6: Host finally writes zero at 0xf4.
// R7: Window steps run even without relocation.
// R8: Header shows vendor and device codes.
// R9: 32-bit target, multiplexed address and data.
// R10: Shared trigger lines need extended chassis.
// R11: No forwarding before the window opens.
`ifndef PCI_WINDOW_PARAMS_SVH
`define PCI_WINDOW_PARAMS_SVH

// ==========================================================
// Configuration header offsets
`define PW_CFG_ID 8'h00
`define PW_CFG_CMD 8'h04
`define PW_CFG_CLASS 8'h08
`define PW_CFG_BRIDGE_REGION_BASE 8'h10
`define PW_CFG_DEVICE_REGION_BASE 8'h14
`define PW_CMD_MEM_EN_BIT 1
`define PW_CMD_MEM_EN 32'h00000002

// ==========================================================
// Region span and bridge offsets
`define PW_SPAN_BITS 12
`define PW_BR_WINDOW 12'h0c4
`define PW_BR_FINAL 12'h0f4
`define PW_BR_UNLOCK 12'h340
`define PW_UNLOCK_KEY 32'h0000aeae
`define PW_WIN_MASK 32'hffffff00
`define PW_WIN_FLAGS 32'h0000008c
`define PW_WIN_EN_BIT 7

// ==========================================================
// Bus commands and timing
`define PW_CMD_MRD 4'h6
`define PW_CMD_MWR 4'h7
`define PW_CMD_CRD 4'ha
`define PW_CMD_CWR 4'hb
`define PW_ABORT_CYCLES 3'h5
`define PW_BRIDGE_REGION_BASE_RESET 32'h00000000
`define PW_DEVICE_REGION_BASE_RESET 32'h00000000

`endif

// ---- common/pci_window_pkg.sv ----
// Types shared by both ends of the PCI window bring-up
package pci_window_pkg;

  typedef enum logic [1:0] {
    T_IDLE,
    T_DATA,
    T_FWD,
    T_RESP
  } tgt_state_t;

  typedef enum logic [1:0] {
    H_IDLE,
    H_ADDR,
    H_DATA
  } host_state_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_CFG_RD,
    OP_CFG_WR,
    OP_MEM_WR
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
  } op_t;

endpackage

// ---- common/pci_bus_if.sv ----
// Interface joining the setup host and the bridge target on a single-target PCI segment
`timescale 1ns/1ps
interface pci_bus_if;
  logic frame_n;
  logic irdy_n;
  logic idsel;
  logic [3:0] cbe_n;
  logic [31:0] host_ad_o;
  logic host_ad_oe;
  logic [31:0] dev_ad_o;
  logic dev_ad_oe;
  logic trdy_n;
  logic devsel_n;
  logic [31:0] ad;

  // Resolved level of the shared address/data lines; idle lines read as zero
  assign ad = host_ad_oe ? host_ad_o : (dev_ad_oe ? dev_ad_o : 32'h00000000);

  modport host (
    output frame_n, irdy_n, idsel, cbe_n, host_ad_o, host_ad_oe,
    input trdy_n, devsel_n, ad
  );

  modport device (
    output dev_ad_o, dev_ad_oe, trdy_n, devsel_n,
    input frame_n, irdy_n, idsel, cbe_n, ad
  );
endinterface

// ---- design/pci_target_end.sv ----
// Bridge target: configuration header, two memory regions and forwarding window to the counter chip
`timescale 1ns/1ps
`include "pci_window_params.svh"
module pci_target_end #(
  parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
  parameter logic [31:0] CLASS_REV = 32'h11000000,
  parameter logic [31:0] BRIDGE_REGION_BASE_RESET = `PW_BRIDGE_REGION_BASE_RESET,
  parameter logic [31:0] DEVICE_REGION_BASE_RESET = `PW_DEVICE_REGION_BASE_RESET
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus
  pci_bus_if.device bus,
  // Counter chip side
  output logic ct_req,
  output logic ct_we,
  output logic [11:0] ct_addr,
  output logic [31:0] ct_wdata,
  input wire logic [31:0] ct_rdata,
  // Status
  output logic window_open,
  output logic unlocked,
  output logic setup_final
);

  // ==========================================================
  // Helpers
  function automatic logic in_region(input logic [31:0] a, input logic [31:0] base);
    in_region = (a[31:`PW_SPAN_BITS] == base[31:`PW_SPAN_BITS]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be_n);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (!be_n[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ==========================================================
  // State
  pci_window_pkg::tgt_state_t state_q;
  logic [31:0] bridge_region_base_q, device_region_base_q, win_q, addr_q, ad_o_q;
  logic [3:0] cmd_q;
  logic mem_en_q, open_q, unlock_q, final_q, cfg_q, fwd_q;
  logic devsel_q, trdy_q, ad_oe_q;
  logic ct_req_q, ct_we_q;
  logic [11:0] ct_addr_q;
  logic [31:0] ct_wdata_q;

  // ==========================================================
  // Address phase decode
  wire logic start = (state_q == pci_window_pkg::T_IDLE) && !bus.frame_n;
  wire logic is_mem = (bus.cbe_n == `PW_CMD_MRD) || (bus.cbe_n == `PW_CMD_MWR); // [R2]
  wire logic is_cfg = bus.idsel && bus.ad[1:0] == 2'b00 &&
                      ((bus.cbe_n == `PW_CMD_CRD) || (bus.cbe_n == `PW_CMD_CWR));
  wire logic hit_br = is_mem && mem_en_q && in_region(bus.ad, bridge_region_base_q); // [R1] [R2]
  wire logic hit_ct = is_mem && mem_en_q && in_region(bus.ad, device_region_base_q) && open_q; // [R11]
  wire logic claim_int = start && (is_cfg || hit_br);
  wire logic claim_fwd = start && hit_ct && !hit_br;
  wire logic [7:0] cfg_off = bus.ad[7:0];
  wire logic [31:0] cfg_rd =
    (cfg_off == `PW_CFG_ID) ? {DEVICE_CODE, VENDOR_CODE} : // [R8]
    (cfg_off == `PW_CFG_CMD) ? {30'h00000000, mem_en_q, 1'b0} :
    (cfg_off == `PW_CFG_CLASS) ? CLASS_REV :
    (cfg_off == `PW_CFG_BRIDGE_REGION_BASE) ? {bridge_region_base_q[31:`PW_SPAN_BITS], 12'h000} : // [R2]
    (cfg_off == `PW_CFG_DEVICE_REGION_BASE) ? {device_region_base_q[31:`PW_SPAN_BITS], 12'h000} : 32'h00000000;
  // Bridge registers are write-only and read as zero
  wire logic [31:0] rd_word = is_cfg ? cfg_rd : 32'h00000000;
  wire logic is_write = (cmd_q == `PW_CMD_MWR) || (cmd_q == `PW_CMD_CWR);
  wire logic do_write = (state_q == pci_window_pkg::T_DATA) && !bus.irdy_n && is_write && !fwd_q;
  wire logic [31:0] wdata = merge(32'h00000000, bus.ad, bus.cbe_n);
  wire logic [11:0] boff = addr_q[11:0];
  wire logic wr_bridge_region_base = do_write && cfg_q && addr_q[7:0] == `PW_CFG_BRIDGE_REGION_BASE;
  wire logic wr_device_region_base = do_write && cfg_q && addr_q[7:0] == `PW_CFG_DEVICE_REGION_BASE;
  wire logic wr_cmd = do_write && cfg_q && addr_q[7:0] == `PW_CFG_CMD && !bus.cbe_n[0];
  wire logic wr_win = do_write && !cfg_q && boff == `PW_BR_WINDOW;
  wire logic wr_unlock = do_write && !cfg_q && boff == `PW_BR_UNLOCK;
  wire logic wr_final = do_write && !cfg_q && boff == `PW_BR_FINAL;
  wire logic win_ok = wdata[`PW_WIN_EN_BIT] &&
                      wdata[31:`PW_SPAN_BITS] == device_region_base_q[31:`PW_SPAN_BITS];

  // ==========================================================
  // Configuration and bridge registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bridge_region_base_q <= BRIDGE_REGION_BASE_RESET;
      device_region_base_q <= DEVICE_REGION_BASE_RESET;
      mem_en_q <= 1'b0;
      win_q <= 32'h00000000;
      open_q <= 1'b0;
      unlock_q <= 1'b0;
      final_q <= 1'b0;
    end
    else
    begin
      if (wr_bridge_region_base)
      begin
        bridge_region_base_q <= merge(bridge_region_base_q, bus.ad, bus.cbe_n); // [R3]
      end
      if (wr_device_region_base)
      begin
        device_region_base_q <= merge(device_region_base_q, bus.ad, bus.cbe_n); // [R3]
      end
      if (wr_cmd)
      begin
        mem_en_q <= bus.ad[`PW_CMD_MEM_EN_BIT];
      end
      if (wr_unlock)
      begin
        unlock_q <= (wdata == `PW_UNLOCK_KEY);
      end
      if (wr_final)
      begin
        final_q <= (wdata == 32'h00000000);
      end
      // Moving the counter region closes the window until it is set again
      if (wr_win)
      begin
        win_q <= wdata;
        open_q <= win_ok; // [R5]
      end
      else if (wr_device_region_base)
      begin
        open_q <= 1'b0; // [R11]
      end
    end
  end

  // ==========================================================
  // Bus handshake and forwarding
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= pci_window_pkg::T_IDLE;
      addr_q <= 32'h00000000;
      cmd_q <= 4'h0;
      cfg_q <= 1'b0;
      fwd_q <= 1'b0;
      devsel_q <= 1'b0;
      trdy_q <= 1'b0;
      ad_oe_q <= 1'b0;
      ad_o_q <= 32'h00000000;
      ct_req_q <= 1'b0;
      ct_we_q <= 1'b0;
      ct_addr_q <= 12'h000;
      ct_wdata_q <= 32'h00000000;
    end
    else
    begin
      case (state_q)
        pci_window_pkg::T_IDLE:
        begin
          if (claim_int || claim_fwd)
          begin
            addr_q <= bus.ad;
            cmd_q <= bus.cbe_n;
            cfg_q <= is_cfg;
            fwd_q <= claim_fwd;
            devsel_q <= 1'b1; // [R9]
          end
          if (claim_int)
          begin
            trdy_q <= 1'b1;
            ad_o_q <= rd_word;
            ad_oe_q <= (bus.cbe_n == `PW_CMD_CRD) || (bus.cbe_n == `PW_CMD_MRD);
            state_q <= pci_window_pkg::T_DATA;
          end
          else if (claim_fwd)
          begin
            state_q <= pci_window_pkg::T_FWD; // [R5]
          end
        end
        pci_window_pkg::T_FWD:
        begin
          if (!bus.irdy_n)
          begin
            ct_req_q <= 1'b1;
            ct_we_q <= is_write;
            ct_addr_q <= addr_q[11:0];
            ct_wdata_q <= bus.ad;
            state_q <= pci_window_pkg::T_RESP;
          end
        end
        pci_window_pkg::T_RESP:
        begin
          // The counter chip answers in the cycle its request is high
          ct_req_q <= 1'b0;
          trdy_q <= 1'b1;
          ad_o_q <= ct_rdata;
          ad_oe_q <= !ct_we_q;
          state_q <= pci_window_pkg::T_DATA;
        end
        default:
        begin
          if (!bus.irdy_n)
          begin
            devsel_q <= 1'b0;
            trdy_q <= 1'b0;
            ad_oe_q <= 1'b0;
            state_q <= pci_window_pkg::T_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  // The shared trigger lines are not handled here; they stay off the bridge [R10]
  assign bus.devsel_n = !devsel_q;
  assign bus.trdy_n = !trdy_q;
  assign bus.dev_ad_o = ad_o_q;
  assign bus.dev_ad_oe = ad_oe_q;
  assign ct_req = ct_req_q;
  assign ct_we = ct_we_q;
  assign ct_addr = ct_addr_q;
  assign ct_wdata = ct_wdata_q;
  assign window_open = open_q;
  assign unlocked = unlock_q;
  assign setup_final = final_q;

endmodule

// ---- design/pci_setup_host.sv ----
// Setup host: runs the bridge bring-up sequence, then offers single accesses to the counter region
`timescale 1ns/1ps
`include "pci_window_params.svh"
module pci_setup_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus
  pci_bus_if.host bus,
  // Bring-up control
  input wire logic start,
  input wire logic relocate,
  input wire logic [31:0] new_bridge_region_base,
  input wire logic [31:0] new_device_region_base,
  output logic init_busy,
  output logic init_done,
  output logic init_fail,
  // Counter region access
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [11:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  output logic [31:0] acc_rdata,
  output logic acc_done,
  output logic acc_fail
);

  // ==========================================================
  // Bring-up steps
  function automatic pci_window_pkg::op_t step_op(input logic [2:0] s, input logic rel,
                                                   input logic [31:0] b0, input logic [31:0] b1);
    pci_window_pkg::op_t o;
    o = '{pci_window_pkg::OP_NONE, 32'h00000000, 32'h00000000};
    case (s)
      // Memory decode goes on first, or the unlock write in the bridge region is never claimed
      3'h0: o = '{pci_window_pkg::OP_CFG_WR, {24'h000000, `PW_CFG_CMD}, `PW_CMD_MEM_EN};
      3'h1: o = '{rel ? pci_window_pkg::OP_CFG_WR : pci_window_pkg::OP_CFG_RD, {24'h000000, `PW_CFG_BRIDGE_REGION_BASE},
                  rel ? b0 : 32'h00000000}; // [R3]
      3'h2: o = '{rel ? pci_window_pkg::OP_MEM_WR : pci_window_pkg::OP_CFG_RD,
                  rel ? b0 + {20'h00000, `PW_BR_UNLOCK} : {24'h000000, `PW_CFG_DEVICE_REGION_BASE},
                  rel ? `PW_UNLOCK_KEY : 32'h00000000}; // [R4]
      3'h3: o = '{rel ? pci_window_pkg::OP_CFG_WR : pci_window_pkg::OP_NONE,
                  {24'h000000, `PW_CFG_DEVICE_REGION_BASE}, b1}; // [R3]
      3'h4: o = '{pci_window_pkg::OP_MEM_WR, b0 + {20'h00000, `PW_BR_WINDOW},
                  (b1 & `PW_WIN_MASK) | `PW_WIN_FLAGS}; // [R5] [R7]
      3'h5: o = '{pci_window_pkg::OP_MEM_WR, b0 + {20'h00000, `PW_BR_FINAL}, 32'h00000000}; // [R6] [R7]
      default: o = o;
    endcase
    step_op = o;
  endfunction

  pci_window_pkg::host_state_t state_q;
  logic [2:0] step_q, wait_q;
  logic [31:0] base0_q, base1_q, ad_o_q, data_q, rdata_q;
  logic [3:0] cbe_q, cmd_q;
  logic frame_q, irdy_q, idsel_q, ad_oe_q, busy_q, done_q, fail_q, acc_q, acc_done_q, acc_fail_q;

  wire pci_window_pkg::op_t op = step_op(step_q, relocate, base0_q, base1_q);
  wire logic op_rd = (op.kind == pci_window_pkg::OP_CFG_RD);
  wire logic op_cfg = op_rd || (op.kind == pci_window_pkg::OP_CFG_WR);
  wire logic [3:0] op_cmd = op_rd ? `PW_CMD_CRD : (op_cfg ? `PW_CMD_CWR : `PW_CMD_MWR);
  wire logic last_step = (step_q == 3'h5);
  wire logic xfer_end = (state_q == pci_window_pkg::H_DATA) && !bus.trdy_n;
  wire logic abort = (state_q == pci_window_pkg::H_DATA) && bus.devsel_n && wait_q == `PW_ABORT_CYCLES;
  wire logic is_rd = (cmd_q == `PW_CMD_CRD) || (cmd_q == `PW_CMD_MRD);

  // ==========================================================
  // Sequencer and bus master
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= pci_window_pkg::H_IDLE;
      step_q <= 3'h0;
      wait_q <= 3'h0;
      base0_q <= 32'h00000000;
      base1_q <= 32'h00000000;
      ad_o_q <= 32'h00000000;
      data_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      cbe_q <= 4'hf;
      cmd_q <= 4'h0;
      frame_q <= 1'b0;
      irdy_q <= 1'b0;
      idsel_q <= 1'b0;
      ad_oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      acc_q <= 1'b0;
      acc_done_q <= 1'b0;
      acc_fail_q <= 1'b0;
    end
    else
    begin
      acc_done_q <= 1'b0;
      acc_fail_q <= 1'b0;
      case (state_q)
        pci_window_pkg::H_IDLE:
        begin
          if (!busy_q && start)
          begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            step_q <= 3'h0;
            base0_q <= new_bridge_region_base;
            base1_q <= new_device_region_base;
          end
          else if (busy_q && op.kind == pci_window_pkg::OP_NONE)
          begin
            step_q <= step_q + 3'h1;
          end
          else if (busy_q || (done_q && acc_req))
          begin
            // Address phase: a bring-up step, or a counter region access once set up
            acc_q <= !busy_q;
            frame_q <= 1'b1;
            ad_oe_q <= 1'b1;
            idsel_q <= busy_q && op_cfg;
            ad_o_q <= busy_q ? op.addr : base1_q + {20'h00000, acc_addr};
            data_q <= busy_q ? op.data : acc_wdata;
            cbe_q <= busy_q ? op_cmd : (acc_we ? `PW_CMD_MWR : `PW_CMD_MRD);
            cmd_q <= busy_q ? op_cmd : (acc_we ? `PW_CMD_MWR : `PW_CMD_MRD);
            state_q <= pci_window_pkg::H_ADDR;
          end
        end
        pci_window_pkg::H_ADDR:
        begin
          frame_q <= 1'b0;
          irdy_q <= 1'b1;
          idsel_q <= 1'b0;
          cbe_q <= 4'h0;
          ad_o_q <= data_q;
          ad_oe_q <= !is_rd;
          wait_q <= 3'h0;
          state_q <= pci_window_pkg::H_DATA;
        end
        default:
        begin
          if (wait_q != `PW_ABORT_CYCLES)
          begin
            wait_q <= wait_q + 3'h1;
          end
          if (xfer_end || abort)
          begin
            irdy_q <= 1'b0;
            ad_oe_q <= 1'b0;
            cbe_q <= 4'hf;
            state_q <= pci_window_pkg::H_IDLE;
            if (acc_q)
            begin
              rdata_q <= bus.ad;
              acc_done_q <= xfer_end;
              acc_fail_q <= abort;
            end
            else if (abort)
            begin
              busy_q <= 1'b0;
              fail_q <= 1'b1;
            end
            else
            begin
              if (is_rd && step_q == 3'h1)
              begin
                base0_q <= bus.ad;
              end
              if (is_rd && step_q == 3'h2)
              begin
                base1_q <= bus.ad;
              end
              step_q <= step_q + 3'h1;
              if (last_step)
              begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign bus.frame_n = !frame_q;
  assign bus.irdy_n = !irdy_q;
  assign bus.idsel = idsel_q;
  assign bus.cbe_n = cbe_q;
  assign bus.host_ad_o = ad_o_q;
  assign bus.host_ad_oe = ad_oe_q;
  assign init_busy = busy_q;
  assign init_done = done_q;
  assign init_fail = fail_q;
  assign acc_rdata = rdata_q;
  assign acc_done = acc_done_q;
  assign acc_fail = acc_fail_q;

endmodule

// ---- bench/pci_window_props.sv ----
// Checker for the bus between the setup host and the bridge target
`timescale 1ns/1ps
`include "pci_window_params.svh"
module pci_window_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host side of the bus
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic [3:0] cbe_n,
  input wire logic host_ad_oe,
  // Device side of the bus
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic dev_ad_oe,
  input wire logic [31:0] ad
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Sequences
  sequence s_cfg_req;
    !frame_n && idsel && (cbe_n == `PW_CMD_CRD || cbe_n == `PW_CMD_CWR) && ad[1:0] == 2'b00;
  endsequence
  sequence s_claim;
    !devsel_n;
  endsequence
  // Nobody claimed: six data cycles, then the host gives up
  sequence s_abort;
    devsel_n [*5] ##[1:2] irdy_n;
  endsequence

  // ==========================================================
  // Properties
  property p_frame_pulse;
    !frame_n |=> frame_n;
  endproperty
  property p_irdy_follows;
    !frame_n |=> !irdy_n;
  endproperty
  property p_cfg_claim;
    s_cfg_req |=> !devsel_n && !trdy_n;
  endproperty
  property p_claim_or_abort;
    !frame_n |=> s_claim or s_abort;
  endproperty
  property p_trdy_bound;
    $fell(devsel_n) |-> ##[0:2] !trdy_n;
  endproperty
  property p_trdy_needs_devsel;
    $fell(trdy_n) |-> !devsel_n;
  endproperty
  property p_release;
    (!trdy_n && !irdy_n) |=> trdy_n && devsel_n && !dev_ad_oe;
  endproperty
  property p_one_driver;
    !(host_ad_oe && dev_ad_oe);
  endproperty

  a_frame_pulse: assert property (p_frame_pulse) else $error("address strobe longer than one cycle");
  a_irdy_follows: assert property (p_irdy_follows) else $error("data phase does not follow address");
  a_cfg_claim: assert property (p_cfg_claim) else $error("configuration access not claimed");
  a_claim_or_abort: assert property (p_claim_or_abort) else $error("neither claim nor abort");
  a_trdy_bound: assert property (p_trdy_bound) else $error("target ready late after claim");
  a_trdy_needs_devsel: assert property (p_trdy_needs_devsel) else $error("ready without claim");
  a_release: assert property (p_release) else $error("target holds bus after transfer");
  a_one_driver: assert property (p_one_driver) else $error("both ends drive the data lines");
endmodule

// ---- bench/tb.sv ----
// Self-checking testbench: setup host and bridge target joined on one bus
`timescale 1ns/1ps
`include "pci_window_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
  // Firmware bases; two distinct 4 KB spans so the regions never overlap
  localparam logic [31:0] FW_B0 = 32'h000d0000;
  localparam logic [31:0] FW_B1 = 32'h000d1000;
  logic mclk, rst, start, relocate, acc_req, acc_we;
  logic [31:0] new_bridge_region_base, new_device_region_base, acc_wdata, ct_rdata, acc_rdata, ct_wdata;
  logic [11:0] acc_addr, ct_addr, ct_addr_s;
  logic init_busy, init_done, init_fail, acc_done, acc_fail;
  logic ct_req, ct_we, window_open, unlocked, setup_final;
  int fail_count, samples_checked, ct_count;
  logic [31:0] rng_q, exp_b0, exp_b1, addr_ph, win_seen, unl_seen, last_wa, last_wd, ct_wd_s, r;
  logic [3:0] cmd_ph;
  logic data_ph, ct_we_s;

  pci_bus_if u_pci_bus_if ();
  pci_target_end #(.BRIDGE_REGION_BASE_RESET(FW_B0), .DEVICE_REGION_BASE_RESET(FW_B1)) u_pci_target_end (
    .mclk(mclk), .rst(rst), .bus(u_pci_bus_if), .ct_req(ct_req), .ct_we(ct_we), .ct_addr(ct_addr),
    .ct_wdata(ct_wdata), .ct_rdata(ct_rdata), .window_open(window_open), .unlocked(unlocked),
    .setup_final(setup_final));
  pci_setup_host u_pci_setup_host (
    .mclk(mclk), .rst(rst), .bus(u_pci_bus_if), .start(start), .relocate(relocate), .new_bridge_region_base(new_bridge_region_base),
    .new_device_region_base(new_device_region_base), .init_busy(init_busy), .init_done(init_done), .init_fail(init_fail),
    .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_done(acc_done), .acc_fail(acc_fail));
  pci_window_props u_pci_window_props (
    .mclk(mclk), .rst(rst), .frame_n(u_pci_bus_if.frame_n), .irdy_n(u_pci_bus_if.irdy_n),
    .idsel(u_pci_bus_if.idsel), .cbe_n(u_pci_bus_if.cbe_n), .host_ad_oe(u_pci_bus_if.host_ad_oe),
    .trdy_n(u_pci_bus_if.trdy_n), .devsel_n(u_pci_bus_if.devsel_n), .dev_ad_oe(u_pci_bus_if.dev_ad_oe),
    .ad(u_pci_bus_if.ad));

  // ==========================================================
  // Clock, random source and expectations
  always #2.5 mclk = ~mclk;

  function automatic logic [31:0] xs();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction

  function automatic logic [31:0] win_value(input logic [31:0] b1);
    return (b1 & 32'hffffff00) | 32'h0000008c;
  endfunction

  // ==========================================================
  // Bus and counter-side monitor
  always @(posedge mclk)
  begin
    data_ph <= !u_pci_bus_if.frame_n;
    if (u_pci_bus_if.frame_n === 1'b0)
    begin
      addr_ph <= u_pci_bus_if.ad;
      cmd_ph <= u_pci_bus_if.cbe_n;
    end
    if (data_ph && cmd_ph === `PW_CMD_MWR)
    begin
      last_wa <= addr_ph;
      last_wd <= u_pci_bus_if.ad;
      if (addr_ph === exp_b0 + 32'h000000c4)
        win_seen <= u_pci_bus_if.ad;
      if (addr_ph === exp_b0 + 32'h00000340)
        unl_seen <= u_pci_bus_if.ad;
    end
    if (ct_req === 1'b1)
    begin
      ct_count <= ct_count + 1;
      ct_we_s <= ct_we;
      ct_addr_s <= ct_addr;
      ct_wd_s <= ct_wdata;
    end
  end

  // ==========================================================
  // Tasks
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic run_init(input logic rl, input logic [31:0] b0, input logic [31:0] b1);
    int n;
    relocate = rl;
    new_bridge_region_base = b0;
    new_device_region_base = b1;
    start = 1'b1;
    tick();
    start = 1'b0;
    `CHK("init_busy", 1'b1, init_busy)
    for (n = 0; n < 400 && init_done !== 1'b1 && init_fail !== 1'b1; n++)
      tick();
    `CHK("init_done", 1'b1, init_done)
    `CHK("init_fail", 1'b0, init_fail)
    `CHK("window_open", 1'b1, window_open)
    `CHK("window word", win_value(exp_b1), win_seen)
    `CHK("final addr", exp_b0 + 32'h000000f4, last_wa)
    `CHK("final data", 32'h00000000, last_wd)
    `CHK("setup_final", 1'b1, setup_final)
    tick();
  endtask

  task automatic access(input logic we, input logic [11:0] a, input logic [31:0] wd);
    int n;
    int c0;
    logic [31:0] rd;
    rd = xs();
    c0 = ct_count;
    ct_rdata = rd;
    acc_we = we;
    acc_addr = a;
    acc_wdata = wd;
    acc_req = 1'b1;
    tick();
    acc_req = 1'b0;
    for (n = 0; n < 40 && acc_done !== 1'b1 && acc_fail !== 1'b1; n++)
      tick();
    `CHK("acc_done", 1'b1, acc_done)
    `CHK("acc_fail", 1'b0, acc_fail)
    `CHK("ct_count", c0 + 1, ct_count)
    `CHK("bus addr", exp_b1 + {20'h00000, a}, addr_ph)
    `CHK("ct_addr", a, ct_addr_s)
    `CHK("ct_we", we, ct_we_s)
    if (we)
      `CHK("ct_wdata", wd, ct_wd_s)
    else
      `CHK("acc_rdata", rd, acc_rdata)
    ct_rdata = ~rd;
    tick();
  endtask

  task automatic accesses();
    int i;
    // Both ends of the 4 KB span first, then random word offsets
    for (i = 0; i < 4; i++)
      access(i[0], i[1] ? 12'hffc : 12'h000, xs());
    for (i = 0; i < 6; i++)
    begin
      r = xs();
      access(r[0], {r[11:2], 2'b00}, xs());
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    relocate = 1'b0;
    acc_req = 1'b0;
    acc_we = 1'b0;
    acc_addr = 12'h000;
    acc_wdata = 32'h00000000;
    ct_rdata = 32'h00000000;
    new_bridge_region_base = 32'h00000000;
    new_device_region_base = 32'h00000000;
    rng_q = 32'h0000c8b2;
    fail_count = 0;
    samples_checked = 0;
    ct_count = 0;
    exp_b0 = FW_B0;
    exp_b1 = FW_B1;
    win_seen = 32'h00000000;
    unl_seen = 32'h00000000;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    `CHK("window_open", 1'b0, window_open)
    `CHK("init_done", 1'b0, init_done)
    run_init(1'b0, 32'h00000000, 32'h00000000);
    `CHK("unlocked", 1'b0, unlocked)
    `CHK("ct_count", 0, ct_count)
    accesses();
    // Reset in mid-run must close the window again
    rst = 1'b1;
    tick();
    rst = 1'b0;
    `CHK("window_open", 1'b0, window_open)
    r = xs();
    exp_b0 = {12'h000, r[19:12], 12'h000};
    exp_b1 = exp_b0 ^ 32'h00001000;
    run_init(1'b1, exp_b0, exp_b1);
    `CHK("unlock word", 32'h0000aeae, unl_seen)
    `CHK("unlocked", 1'b1, unlocked)
    accesses();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
endmodule
